// ---- rtl/omr_map.svh ----
/*
  Constant map of the operating-mode register block: byte offsets, field
  positions, mode encodings, reset values and bus codes.
  Assumes it is included by bare name from files of the omr block.
*/
`ifndef OMR_MAP_SVH
`define OMR_MAP_SVH

// ==========================================================
// register byte offsets (low address bits only)
`define OMR_ADDR_MSB 3
`define OMR_OFS_MODE 4'h0
`define OMR_OFS_PULL 4'h4

// ==========================================================
// operating_mode_control field positions
`define OMR_MODE_SELECT_BIT2 7
`define OMR_MODE_SELECT_BIT0 5
`define OMR_INTERNAL_VISIBILITY_ENABLE 3
`define OMR_EMK 1
`define OMR_EME 0

// ==========================================================
// mode encodings of mode_select_field
`define OMR_M_SSC 3'h0
`define OMR_M_EMN 3'h1
`define OMR_M_STEST 3'h2
`define OMR_M_EMW 3'h3
`define OMR_M_NSC 3'h4
`define OMR_M_NEN 3'h5
`define OMR_M_PERIPH 3'h6
`define OMR_M_NEW 3'h7

// ==========================================================
// pull_control_register fields, reset and masks
`define OMR_PULL_K 7
`define OMR_PULL_E 4
`define OMR_PULL_B 1
`define OMR_PULL_A 0
`define OMR_PULL_RST 8'h00
`define OMR_PULL_IMPL 8'h93
`define OMR_PE_PULL_PINS 8'h9f

// ==========================================================
// bus codes and timing
`define OMR_HTRANS_ACT 1
`define OMR_HSIZE_WORD 3'h2
`define OMR_RD_PAD 24'h000000
`define OMR_INIT_CYCLES 3'h5

`endif

// ---- rtl/omr_pkg.sv ----
/*
  Types shared by the operating-mode register block.
  Assumes omr_map.svh holds the numeric constants.
*/
package omr_pkg;
  // data-phase state of the bus slave
  typedef enum logic [1:0] {st_idle, st_wr, st_rd_wait, st_rd_done} omr_bus_st_t;
  // three-bit operating mode
  typedef logic [2:0] omr_mode_t;
endpackage

// ---- rtl/omr_sync3.sv ----
/*
  Three-flop level synchroniser with agreement filter.
  Assumes raw comes from another clock domain or a pin.
*/
`timescale 1ns/1ns
`default_nettype none
module omr_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // asynchronous level in, filtered level out
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level
);
  // ==========================================================
  // chain
  logic [W-1:0] s1_q; // metastable stage, read only by s2
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] agree;

  // only the later two stages are compared
  assign agree = ~(s2_q ^ s3_q);

  // shift the chain, take a bit once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (agree & s3_q) | (~agree & lvl_q);
    end
  end

  assign level = lvl_q;
endmodule
`default_nettype wire

// ---- rtl/omr_mode_ctl.sv ----
/*
  Operating-mode register block: mode field with its write permissions,
  visibility and port emulation controls, pull control, map decode.
  Assumes an AHB-Lite master, static mode strap pins, a secure pin,
  and port direction levels from logic on the same clock.
*/
//
// What this block does
// - report operating mode in three-bit field
// - lowest mode bit set: mode writes ignored
// - special single chip: any write except to 110
// - normal single chip: one write, expanded only
// - special to normal single chip keeps one write
// - secure state blocks all mode writes
// - written changes take effect one cycle later
// - peripheral mode: register inaccessible, reset values apply
// - visibility bit: once, never, anytime by class
// - port K emulation unmaps port K registers outside single chip
// - port E emulation unmaps port E registers outside single chip
// - expanded/peripheral: registers excluded, accesses echoed out
// - pull control read/write anytime when mapped
// - pull enable acts per port, inputs only
`timescale 1ns/1ns
`default_nettype none
`include "omr_map.svh"
module omr_mode_ctl
  import omr_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pins
  input wire logic [2:0] mode_strap,
  input wire logic secure_mode,
  // port direction levels, 1 = output
  input wire logic [7:0] port_a_dir,
  input wire logic [7:0] port_b_dir,
  input wire logic [7:0] port_e_dir,
  input wire logic [7:0] port_k_dir,
  // mode and configuration
  output logic [2:0] mode_select_field,
  output logic internal_visibility_enable,
  output logic emulate_port_k_enable,
  output logic emulate_port_e_enable,
  // map decode
  output logic core_regs_mapped,
  output logic port_k_regs_mapped,
  output logic port_e_regs_mapped,
  output logic external_echo,
  // pull activation per pin
  output logic [7:0] pull_active_a,
  output logic [7:0] pull_active_b,
  output logic [7:0] pull_active_e,
  output logic [7:0] pull_active_k
);
  // ==========================================================
  // mode classes
  function automatic logic f_single(input omr_mode_t m);
    f_single = (m == `OMR_M_SSC) || (m == `OMR_M_NSC);
  endfunction

  function automatic logic f_special(input omr_mode_t m);
    f_special = (m == `OMR_M_SSC) || (m == `OMR_M_STEST) || (m == `OMR_M_PERIPH);
  endfunction

  function automatic logic f_emul(input omr_mode_t m);
    f_emul = (m == `OMR_M_EMN) || (m == `OMR_M_EMW);
  endfunction

  // ==========================================================
  // declarations
  logic [2:0] strap_lvl; // filtered strap pins
  logic secure_lvl; // filtered secure pin
  logic [2:0] init_cnt_q; // wait for the strap chain to fill
  logic loaded_q; // mode taken from straps
  omr_mode_t mode_q; // current operating mode
  omr_mode_t mode_d;
  logic internal_visibility_enable_q;
  logic emk_q;
  logic eme_q;
  logic norm_once_q; // write-once already used in normal mode
  logic [7:0] pull_q;
  omr_bus_st_t st_q;
  logic take; // address phase accepted
  logic word_acc; // whole-word access
  logic [`OMR_ADDR_MSB:0] ofs;
  logic sel_mode_q; // data phase targets mode register
  logic sel_pull_q; // data phase targets pull register
  logic wr_pend_q; // write waiting for commit
  logic wr_mode_q;
  logic wr_pull_q;
  logic [7:0] wr_data_q;
  logic commit_mode;
  logic commit_pull;
  logic echo_q;
  logic [31:0] hrdata_q;
  logic [7:0] mode_val;
  logic single;
  logic periph;

  // ==========================================================
  // pin synchronisers
  omr_sync3 #(.W(3)) u_strap_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .raw(mode_strap),
    .level(strap_lvl)
  );

  omr_sync3 #(.W(1)) u_secure_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .raw(secure_mode),
    .level(secure_lvl)
  );

  // ==========================================================
  // strap capture after reset release
  // the field follows the strap level every cycle until the count ends, never at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_cnt_q <= 3'h0;
      loaded_q <= 1'b0;
    end else if (!loaded_q) begin
      if (init_cnt_q == `OMR_INIT_CYCLES) begin
        loaded_q <= 1'b1;
      end else begin
        init_cnt_q <= init_cnt_q + 3'h1;
      end
    end
  end

  // ==========================================================
  // decode of the current mode
  assign single = f_single(mode_q);
  assign periph = (mode_q == `OMR_M_PERIPH);
  // core registers vanish in expanded and peripheral modes
  assign core_regs_mapped = loaded_q && single;
  // port k: kept in single chip, never in peripheral
  assign port_k_regs_mapped = single || (!periph && !emk_q);
  // port e: kept in single chip, else follows emulation bit
  assign port_e_regs_mapped = single || !eme_q;

  // ==========================================================
  // mode field next value
  always_comb begin
    mode_d = mode_q;
    // secure state and odd modes lock the field
    if (commit_mode && !secure_lvl && !mode_q[0]) begin
      if (!mode_q[2]) begin
        // special single chip or test, never into peripheral
        // entering normal single chip leaves its own write open
        if (wr_data_q[`OMR_MODE_SELECT_BIT2:`OMR_MODE_SELECT_BIT0] != `OMR_M_PERIPH) begin
          mode_d = wr_data_q[`OMR_MODE_SELECT_BIT2:`OMR_MODE_SELECT_BIT0];
        end
      end else if (mode_q == `OMR_M_NSC) begin
        // top bit fixed, only expanded targets
        if (wr_data_q[`OMR_MODE_SELECT_BIT2:`OMR_MODE_SELECT_BIT0] == `OMR_M_NEN ||
            wr_data_q[`OMR_MODE_SELECT_BIT2:`OMR_MODE_SELECT_BIT0] == `OMR_M_NEW) begin
          mode_d = wr_data_q[`OMR_MODE_SELECT_BIT2:`OMR_MODE_SELECT_BIT0];
        end
      end
    end
  end

  // mode register; every target accepted from normal single chip has the low bit set, so the
  // single normal-chip write is used up by the mode itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= `OMR_M_SSC;
    end else if (!loaded_q) begin
      mode_q <= strap_lvl;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ==========================================================
  // visibility and emulation bits
  // reset values follow the strapped mode, peripheral included
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_visibility_enable_q <= 1'b0;
      emk_q <= 1'b0;
      eme_q <= 1'b0;
      norm_once_q <= 1'b0;
    end else if (!loaded_q) begin
      internal_visibility_enable_q <= f_emul(strap_lvl) || (strap_lvl == `OMR_M_STEST);
      emk_q <= f_emul(strap_lvl);
      eme_q <= f_emul(strap_lvl);
    end else if (commit_mode) begin
      if (f_special(mode_q)) begin
        // special: all three write anytime
        internal_visibility_enable_q <= wr_data_q[`OMR_INTERNAL_VISIBILITY_ENABLE];
        emk_q <= wr_data_q[`OMR_EMK];
        eme_q <= wr_data_q[`OMR_EME];
      end else if (!f_emul(mode_q) && !norm_once_q) begin
        // normal: visibility and port k once, port e never
        internal_visibility_enable_q <= wr_data_q[`OMR_INTERNAL_VISIBILITY_ENABLE];
        emk_q <= wr_data_q[`OMR_EMK];
        norm_once_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // pull control register, unimplemented bits stay zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pull_q <= `OMR_PULL_RST;
    end else if (commit_pull) begin
      pull_q <= wr_data_q & `OMR_PULL_IMPL;
    end
  end

  // one enable per port, pulls only on pins set as inputs
  assign pull_active_a = {8{pull_q[`OMR_PULL_A]}} & ~port_a_dir;
  assign pull_active_b = {8{pull_q[`OMR_PULL_B]}} & ~port_b_dir;
  assign pull_active_e = {8{pull_q[`OMR_PULL_E]}} & ~port_e_dir & `OMR_PE_PULL_PINS;
  assign pull_active_k = {8{pull_q[`OMR_PULL_K]}} & ~port_k_dir;

  // ==========================================================
  // bus address phase
  assign ofs = haddr[`OMR_ADDR_MSB:0];
  assign word_acc = (hsize == `OMR_HSIZE_WORD);
  assign take = hsel && hready && htrans[`OMR_HTRANS_ACT];

  // latch target; unmapped registers decode as no target
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_mode_q <= 1'b0;
      sel_pull_q <= 1'b0;
    end else if (take) begin
      sel_mode_q <= word_acc && core_regs_mapped && (ofs == `OMR_OFS_MODE);
      sel_pull_q <= word_acc && core_regs_mapped && (ofs == `OMR_OFS_PULL);
    end else if (hready) begin
      sel_mode_q <= 1'b0;
      sel_pull_q <= 1'b0;
    end
  end

  // accesses to removed registers are flagged for the external bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      echo_q <= 1'b0;
    end else begin
      echo_q <= take && !core_regs_mapped &&
                (ofs == `OMR_OFS_MODE || ofs == `OMR_OFS_PULL);
    end
  end
  assign external_echo = echo_q;

  // ==========================================================
  // data-phase state
  // a read waits while a write commits so it sees the new value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= st_idle;
    end else if (take) begin
      st_q <= hwrite ? st_wr : st_rd_wait;
    end else begin
      unique case (st_q)
        st_rd_wait: st_q <= wr_pend_q ? st_rd_wait : st_rd_done;
        st_idle, st_wr, st_rd_done: st_q <= st_idle;
      endcase
    end
  end

  // write data are held one cycle, then committed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_mode_q <= 1'b0;
      wr_pull_q <= 1'b0;
      wr_data_q <= 8'h00;
    end else begin
      wr_pend_q <= (st_q == st_wr);
      wr_mode_q <= (st_q == st_wr) && sel_mode_q;
      wr_pull_q <= (st_q == st_wr) && sel_pull_q;
      if (st_q == st_wr) begin
        wr_data_q <= hwdata[7:0];
      end
    end
  end
  assign commit_mode = wr_mode_q;
  assign commit_pull = wr_pull_q;

  // ==========================================================
  // read data
  // gaps at bits 4 and 2 read as zero
  assign mode_val = {mode_q, 1'b0, internal_visibility_enable_q, 1'b0, emk_q, eme_q};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (st_q == st_rd_wait && !wr_pend_q) begin
      if (sel_mode_q) begin
        hrdata_q <= {`OMR_RD_PAD, mode_val};
      end else if (sel_pull_q) begin
        hrdata_q <= {`OMR_RD_PAD, pull_q};
      end else begin
        hrdata_q <= 32'h00000000;
      end
    end
  end

  // stalls until straps load and during the read wait
  assign hreadyout = loaded_q && (st_q != st_rd_wait);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // ==========================================================
  // outputs
  assign mode_select_field = mode_q;
  assign internal_visibility_enable = internal_visibility_enable_q;
  assign emulate_port_k_enable = emk_q;
  assign emulate_port_e_enable = eme_q;

  // ==========================================================
  // assertions
  property p_odd_lock;
    @(posedge hclk) disable iff (!hresetn)
    loaded_q && mode_q[0] |=> $stable(mode_q);
  endproperty
  a_odd_lock: assert property (p_odd_lock) else $error("odd mode changed");

  property p_no_periph;
    @(posedge hclk) disable iff (!hresetn)
    loaded_q && !periph |=> mode_q != `OMR_M_PERIPH;
  endproperty
  a_no_periph: assert property (p_no_periph) else $error("entered peripheral");

  property p_nsc_top;
    @(posedge hclk) disable iff (!hresetn)
    loaded_q && mode_q == `OMR_M_NSC |=> mode_q[2] && (mode_q == `OMR_M_NSC || mode_q[0]);
  endproperty
  a_nsc_top: assert property (p_nsc_top) else $error("bad normal target");

  property p_secure;
    @(posedge hclk) disable iff (!hresetn)
    loaded_q && secure_lvl && commit_mode |=> $stable(mode_q);
  endproperty
  a_secure: assert property (p_secure) else $error("mode written in secure");

  property p_delay;
    @(posedge hclk) disable iff (!hresetn)
    loaded_q && $changed(mode_q) |-> $past(wr_pend_q) && $past(st_q, 2) == st_wr;
  endproperty
  a_delay: assert property (p_delay) else $error("mode change not delayed");

  property p_periph_read;
    @(posedge hclk) disable iff (!hresetn)
    periph && st_q == st_rd_done |-> hrdata_q == 32'h00000000;
  endproperty
  a_periph_read: assert property (p_periph_read) else $error("peripheral read");

  property p_emul_internal_visibility_enable;
    @(posedge hclk) disable iff (!hresetn)
    loaded_q && f_emul(mode_q) |=> $stable(internal_visibility_enable_q) && $stable(eme_q);
  endproperty
  a_emul_internal_visibility_enable: assert property (p_emul_internal_visibility_enable) else $error("emulation bit written");

  property p_k_map;
    @(posedge hclk) disable iff (!hresetn)
    periph || (!single && emk_q) |-> !port_k_regs_mapped;
  endproperty
  a_k_map: assert property (p_k_map) else $error("port k mapped");

  property p_e_map;
    @(posedge hclk) disable iff (!hresetn)
    single |-> port_e_regs_mapped;
  endproperty
  a_e_map: assert property (p_e_map) else $error("port e unmapped");

  property p_gap_bits;
    @(posedge hclk) disable iff (!hresetn)
    st_q == st_rd_done && sel_mode_q |-> !hrdata_q[4] && !hrdata_q[2];
  endproperty
  a_gap_bits: assert property (p_gap_bits) else $error("gap bit set");

  property p_pull_in;
    @(posedge hclk) disable iff (!hresetn)
    |pull_active_k |-> pull_q[`OMR_PULL_K] && !(|(pull_active_k & port_k_dir));
  endproperty
  a_pull_in: assert property (p_pull_in) else $error("pull on output");

  c_to_nsc: cover property (@(posedge hclk) disable iff (!hresetn)
    loaded_q && !mode_q[2] ##1 mode_q == `OMR_M_NSC);
  c_to_exp: cover property (@(posedge hclk) disable iff (!hresetn)
    mode_q == `OMR_M_NSC ##1 mode_q == `OMR_M_NEW);
  c_secure_blk: cover property (@(posedge hclk) disable iff (!hresetn)
    secure_lvl && commit_mode);
endmodule
`default_nettype wire

// ---- test/omr_mode_ctl_tb.sv ----
/*
  Self-checking bench for the operating-mode register block: strap reset
  values, mode write permissions, secure lockout, write timing, map decode,
  pull control and pull activation.
  Assumes omr_mode_ctl is the only bus slave and hready loops back.
*/
`timescale 1ns/1ns
`default_nettype none
`include "omr_map.svh"

// one compare: counts, and reports a mismatch at once
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module omr_mode_ctl_tb;
  // ==========================================================
  // design signals
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, secure_mode;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, mode_strap, mode_select_field;
  logic [7:0] port_a_dir, port_b_dir, port_e_dir, port_k_dir;
  logic [7:0] pull_active_a, pull_active_b, pull_active_e, pull_active_k;
  logic internal_visibility_enable, emulate_port_k_enable, emulate_port_e_enable;
  logic core_regs_mapped, port_k_regs_mapped, port_e_regs_mapped, external_echo;
  // bench state
  int fails = 0; // mismatches
  int check_count = 0; // compares made
  int cycles = 0; // timeout counter
  int unsigned seed_val; // seed call result, unused
  logic echo_seen; // echo pulse seen in last data phase
  logic [31:0] rd; // last read data
  logic [7:0] w, ev; // pull value, expected value

  // single slave: its ready is the bus ready
  assign hready = hreadyout;

  // ==========================================================
  // device under test
  omr_mode_ctl i_omr_mode_ctl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mode_strap(mode_strap), .secure_mode(secure_mode),
    .port_a_dir(port_a_dir), .port_b_dir(port_b_dir),
    .port_e_dir(port_e_dir), .port_k_dir(port_k_dir),
    .mode_select_field(mode_select_field),
    .internal_visibility_enable(internal_visibility_enable),
    .emulate_port_k_enable(emulate_port_k_enable),
    .emulate_port_e_enable(emulate_port_e_enable),
    .core_regs_mapped(core_regs_mapped), .port_k_regs_mapped(port_k_regs_mapped),
    .port_e_regs_mapped(port_e_regs_mapped), .external_echo(external_echo),
    .pull_active_a(pull_active_a), .pull_active_b(pull_active_b),
    .pull_active_e(pull_active_e), .pull_active_k(pull_active_k)
  );

  // ==========================================================
  // clock, 8 ns period
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end

  // ==========================================================
  // expectations
  // mode reset image: emulation sets all three controls, special test only visibility
  function automatic logic [7:0] rst_val(input logic [2:0] m);
    logic v;
    v = (m == 3'h1) || (m == 3'h3);
    return {m, 1'b0, v || (m == 3'h2), 1'b0, v, v};
  endfunction

  // core registers are on chip only in the two single-chip modes
  function automatic logic mapped(input logic [2:0] m);
    return (m == 3'h0) || (m == 3'h4);
  endfunction

  // ==========================================================
  // bus and check tasks
  // verdict and end of run
  task automatic test_done();
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // reset with a strap, then wait for the slave to come ready
  task automatic do_reset(input logic [2:0] s);
    @(posedge hclk);
    hresetn <= 1'b0;
    mode_strap <= s;
    htrans <= 2'b00;
    hsel <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // only the bench timeout ends this wait
    @(negedge hclk);
    while (hreadyout !== 1'b1) begin
      @(negedge hclk);
    end
  endtask

  // one single word transfer; address held until ready, data held until ready
  task automatic bus_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    logic got;
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'h2;
    // ready is read where it has settled, ahead of the edge that samples it
    do begin
      @(negedge hclk);
      got = hreadyout;
      @(posedge hclk);
    end while (got !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    n = 0;
    do begin
      @(negedge hclk);
      got = hreadyout;
      rd = hrdata;
      // the echo pulse belongs to the first data-phase cycle
      if (n == 0) echo_seen = external_echo;
      n++;
      @(posedge hclk);
    end while (got !== 1'b1);
    `CHK("hresp", 1'b0, hresp)
  endtask

  // write the mode register, let the commit land, check the field
  task automatic wr_mode(input logic [7:0] d, input logic [2:0] em);
    bus_xfer(1'b1, 32'h0, 32'(d));
    @(posedge hclk);
    #1;
    `CHK("mode_select_field", em, mode_select_field)
  endtask

  // map decode for a mode and the two emulation controls
  task automatic chk_map(input logic [2:0] m, input logic k, input logic e);
    logic s;
    s = mapped(m);
    `CHK("core_regs_mapped", s, core_regs_mapped)
    `CHK("port_k_regs_mapped", s | (m != 3'h6 && !k), port_k_regs_mapped)
    `CHK("port_e_regs_mapped", s | !e, port_e_regs_mapped)
  endtask

  // ==========================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mode_strap = 3'h0;
    secure_mode = 1'b0;
    port_a_dir = 8'h00;
    port_b_dir = 8'h00;
    port_e_dir = 8'h00;
    port_k_dir = 8'h00;
    seed_val = $urandom(22);
    // every strap: reset image, map, read, and a zero mode write that must leave the field unchanged
    for (int m = 0; m < 8; m++) begin
      do_reset(m[2:0]);
      #1;
      ev = rst_val(m[2:0]);
      `CHK("mode_select_field", m[2:0], mode_select_field)
      `CHK("internal_visibility_enable", ev[3], internal_visibility_enable)
      `CHK("emulate_port_k_enable", ev[1], emulate_port_k_enable)
      `CHK("emulate_port_e_enable", ev[0], emulate_port_e_enable)
      chk_map(m[2:0], ev[1], ev[0]);
      bus_xfer(1'b0, 32'h0, 32'h0);
      if (!mapped(m[2:0])) ev = 8'h00;
      `CHK("mode_read", 32'(ev), rd)
      wr_mode(8'h00, m[2:0]);
      `CHK("external_echo", !mapped(m[2:0]), echo_seen)
    end
    // special single chip: secure lockout, peripheral target, free writes
    do_reset(3'h0);
    @(posedge hclk);
    secure_mode <= 1'b1;
    repeat (6) @(posedge hclk);
    wr_mode(8'h40, 3'h0);
    @(posedge hclk);
    secure_mode <= 1'b0;
    repeat (6) @(posedge hclk);
    wr_mode(8'hc0, 3'h0);
    wr_mode(8'hff & 8'h1f, 3'h0);
    `CHK("internal_visibility_enable", 1'b1, internal_visibility_enable)
    chk_map(3'h0, 1'b1, 1'b1);
    bus_xfer(1'b0, 32'h0, 32'h0);
    `CHK("mode_read", 32'h0000000b, rd)
    // pull control: random values and directions, all pulls once
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 8'hff : 8'($urandom);
      bus_xfer(1'b1, 32'h4, 32'(w));
      @(posedge hclk);
      port_a_dir <= 8'($urandom);
      port_b_dir <= 8'($urandom);
      port_e_dir <= 8'($urandom);
      port_k_dir <= 8'($urandom);
      @(posedge hclk);
      #1;
      `CHK("pull_active_a", {8{w[0]}} & ~port_a_dir, pull_active_a)
      `CHK("pull_active_b", {8{w[1]}} & ~port_b_dir, pull_active_b)
      `CHK("pull_active_e", {8{w[4]}} & ~port_e_dir & 8'h9f, pull_active_e)
      `CHK("pull_active_k", {8{w[7]}} & ~port_k_dir, pull_active_k)
      bus_xfer(1'b0, 32'h4, 32'h0);
      `CHK("pull_read", 32'(w & 8'h93), rd)
    end
    bus_xfer(1'b0, 32'h8, 32'h0);
    `CHK("unused_read", 32'h0, rd)
    // straight to expanded narrow with both emulations: everything leaves the map
    wr_mode(8'ha3, 3'h5);
    chk_map(3'h5, 1'b1, 1'b1);
    bus_xfer(1'b0, 32'h4, 32'h0);
    `CHK("pull_read", 32'h0, rd)
    `CHK("external_echo", 1'b1, echo_seen)
    // write timing: old value in the cycle after the data phase, new one later
    do_reset(3'h0);
    bus_xfer(1'b1, 32'h0, 32'h40);
    #1;
    `CHK("mode_select_field", 3'h0, mode_select_field)
    @(posedge hclk);
    #1;
    `CHK("mode_select_field", 3'h2, mode_select_field)
    chk_map(3'h2, 1'b0, 1'b0);
    // normal single chip: controls write once, mode only to expanded
    do_reset(3'h0);
    wr_mode(8'h80, 3'h4);
    wr_mode(8'h88, 3'h4);
    wr_mode(8'hc0, 3'h4);
    wr_mode(8'h83, 3'h4);
    `CHK("internal_visibility_enable", 1'b1, internal_visibility_enable)
    `CHK("emulate_port_k_enable", 1'b0, emulate_port_k_enable)
    `CHK("emulate_port_e_enable", 1'b0, emulate_port_e_enable)
    wr_mode(8'he0, 3'h7);
    wr_mode(8'ha0, 3'h7);
    `CHK("external_echo", 1'b1, echo_seen)
    test_done();
  end
endmodule
`default_nettype wire
